// ===== core/ckc_pkg.sv
// Shared constants and types for the clock and synthesizer controller
package ckc_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] CKC_CLOCK_CONTROL_ADDR = 8'h8f;
  localparam logic [7:0] CKC_PLL_CONTROL_ADDR   = 8'he9;
  localparam logic [7:0] CKC_REF_DIV_ADDR       = 8'hee;
  localparam logic [7:0] CKC_FB_DIV_ADDR        = 8'hef;

  // Field positions in clock_control
  localparam int CKC_TWO_WIRE_BIT = 7;
  localparam int CKC_WATCHDOG_BIT = 6;
  localparam int CKC_SERIAL_BIT   = 4;
  localparam int CKC_TIMER1_BIT   = 2;
  localparam int CKC_TIMER0_BIT   = 1;
  localparam int CKC_DOUBLE_BIT   = 0;

  // Field positions in pll_control
  localparam int CKC_FB_LOW_MSB = 7;
  localparam int CKC_FB_LOW_LSB = 6;
  localparam int CKC_HOLD_BIT   = 3;
  localparam int CKC_ENABLE_BIT = 1;
  localparam int CKC_LOCK_BIT   = 0;

  // Reference divider field top bit
  localparam int CKC_REF_DIV_MSB = 6;

  // Reset values
  localparam logic [7:0] CKC_CLOCK_CONTROL_RST = 8'h00;
  localparam logic [7:0] CKC_PLL_CONTROL_RST   = 8'h08;
  localparam logic [7:0] CKC_REF_DIV_RST       = 8'h00;
  localparam logic [7:0] CKC_FB_DIV_RST        = 8'h00;

  // CPU ticks per machine cycle (12 osc standard, 6 osc double)
  localparam logic [2:0] CKC_TICKS_PER_MC = 3'd6;

  // Lock detector: allowed edge skew in cycles, good pairs to lock
  localparam logic [7:0] CKC_LOCK_WINDOW = 8'h04;
  localparam logic [3:0] CKC_LOCK_PAIRS  = 4'h8;

  // Speed modes of the CPU and peripheral clocks
  typedef enum logic {CKC_STANDARD_SPEED, CKC_DOUBLE_SPEED} ckc_speed_t;

endpackage

// ===== core/ckc_pfd_if.sv
// Link between the controller and the phase compare and lock detector
`timescale 1ns/1ps
interface ckc_pfd_if;
  logic [6:0] ref_div_value; // Reference divider setting
  logic [9:0] fb_div;        // Feedback divider setting
  logic       hold;          // Synthesizer held in reset
  logic       enable;        // Synthesizer enabled
  logic       vco_tick;      // One-cycle tick from the oscillator loop
  logic       up;            // Raise frequency pulse
  logic       down;          // Lower frequency pulse
  logic       locked;        // Lock indication

  modport ctl (output ref_div_value, fb_div, hold, enable, vco_tick,
               input up, down, locked);
  modport pfd (input ref_div_value, fb_div, hold, enable, vco_tick,
               output up, down, locked);
endinterface

// ===== core/ckc_pfd.sv
// Phase-frequency compare and lock detect for the frequency synthesizer
`timescale 1ns/1ps
module ckc_pfd
  import ckc_pkg::*;
(
  input  wire logic core_clk, // Oscillator clock
  input  wire logic rst_b,    // Synchronous reset, active low
  ckc_pfd_if.pfd    pfd_bus   // Divider settings in, compare results out
);

  logic [6:0] ref_cnt_r;  // Reference divider count
  logic [9:0] fb_cnt_r;   // Feedback divider count
  logic       up_r;       // Raise pulse
  logic       down_r;     // Lower pulse
  logic [7:0] skew_r;     // Cycles one edge has waited for the other
  logic [3:0] good_r;     // Consecutive aligned edge pairs
  logic       lock_r;     // Lock flag
  logic       run;        // Detector active
  logic       ref_edge;   // Divided reference edge
  logic       fb_edge;    // Divided feedback edge
  logic       pair_done;  // Both edges of a pair seen
  logic       miss;       // Pair too far apart

  assign run       = pfd_bus.enable & ~pfd_bus.hold;
  assign ref_edge  = run & (ref_cnt_r == pfd_bus.ref_div_value);
  assign fb_edge   = run & pfd_bus.vco_tick & (fb_cnt_r == pfd_bus.fb_div);
  assign pair_done = (up_r | ref_edge) & (down_r | fb_edge);
  assign miss      = skew_r > CKC_LOCK_WINDOW;

  // RL15 reference divider
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run || ref_edge) begin
      ref_cnt_r <= 7'h00;
    end else begin
      ref_cnt_r <= ref_cnt_r + 7'h01;
    end
  end

  // RL15 feedback divider
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run || fb_edge) begin
      fb_cnt_r <= 10'h000;
    end else if (pfd_bus.vco_tick) begin
      fb_cnt_r <= fb_cnt_r + 10'h001;
    end
  end

  // RL15 up and down pulses
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run || pair_done) begin
      up_r   <= 1'b0;
      down_r <= 1'b0;
    end else begin
      up_r   <= up_r | ref_edge;
      down_r <= down_r | fb_edge;
    end
  end

  // Skew counter saturates just past the window
  always_ff @(posedge core_clk) begin
    if (!rst_b || !(up_r | down_r) || pair_done) begin
      skew_r <= 8'h00;
    end else if (!miss) begin
      skew_r <= skew_r + 8'h01;
    end
  end

  // RL11 lock set and lost by hardware
  always_ff @(posedge core_clk) begin
    if (!rst_b || !run || miss) begin
      good_r <= 4'h0;
      lock_r <= 1'b0;
    end else begin
      if (pair_done && good_r != CKC_LOCK_PAIRS) begin
        good_r <= good_r + 4'h1;
      end
      if (good_r == CKC_LOCK_PAIRS) begin
        lock_r <= 1'b1;
      end
    end
  end

  assign pfd_bus.up     = up_r;
  assign pfd_bus.down   = down_r;
  assign pfd_bus.locked = lock_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  lock_needs_run_a: assert property (!run |=> !lock_r) // RL11
    else $error("lock held while detector stopped");
  lock_lost_a: assert property (run && miss |=> !lock_r && good_r == 4'h0) // RL11
    else $error("lock kept after skew miss");
  pulse_pair_a: assert property (up_r && down_r |-> 1'b0) // RL15
    else $error("up and down both pending");

endmodule

// ===== core/ckc_controller.sv
// Clock controller: speed modes, peripheral clock selects, synthesizer control
//
// Behaviour
// RL1 - Machine cycle: 12 or 6 oscillator periods
// RL2 - Reset starts standard mode, boot default permitting
// RL3 - Standard halves oscillator; double runs at oscillator
// RL4 - Flash variant loads speed from boot strap
// RL5 - Two-wire select bit picks oscillator half
// RL6 - Watchdog select bit picks oscillator half
// RL7 - Serial select bit picks oscillator half
// RL8 - Timer selects pick oscillator half
// RL9 - Software keeps reserved clock bits clear
// RL10 - Enable bit starts and stops synthesizer
// RL11 - Lock flag hardware owned, writes ignored
// RL12 - Hold bit resets synthesizer, set at reset
// RL13 - Feedback divider ten bits, split registers
// RL14 - Reference divider seven bits, top reads zero
// RL15 - Compare divided edges, pulse up/down, lock
// RL16 - Software waits for lock before use
// RL17 - Reserved control bits always read zero
// RL18 - Peripheral clock feeds timers, card, converter
// RL19 - Clocks gated by power reduction mode
// RL20 - Synthesizer clock feeds audio and USB
// RL21 - Speed switch without shortened clock pulses
`timescale 1ns/1ps
module ckc_controller
  import ckc_pkg::*;
#(
  parameter logic FLASH_VARIANT = 1'b1 // Strap-loaded speed when set
) (
  input  wire logic       core_clk,           // Oscillator clock, 40 MHz
  input  wire logic       rst_b,              // Synchronous reset, active low
  input  wire logic [7:0] sfr_addr,           // Register address
  input  wire logic       sfr_wr,             // Write strobe
  input  wire logic       sfr_rd,             // Read strobe
  input  wire logic [7:0] sfr_wdata,          // Write data
  output logic      [7:0] sfr_rdata,          // Read data, one cycle later
  input  wire logic       boot_speed_default, // Boot speed strap
  input  wire logic       idle_mode,          // Idle power reduction
  input  wire logic       power_down,         // Power-down reduction
  input  wire logic       vco_tick,           // Oscillator loop tick
  output logic            cpu_clk_en,         // CPU clock tick
  output logic            per_clk_en,         // Peripheral clock tick
  output logic            machine_cycle,      // Machine cycle end tick
  output logic            timer0_clk_en,      // Timer 0 clock tick
  output logic            timer1_clk_en,      // Timer 1 clock tick
  output logic            serial_clk_en,      // Serial modes 0/2 tick
  output logic            watchdog_clk_en,    // Watchdog clock tick
  output logic            two_wire_clk_en,    // Two-wire clock tick
  output logic            synth_run,          // Synthesizer running
  output logic            synth_hold,         // Synthesizer in reset
  output logic            synth_up,           // Charge pump raise
  output logic            synth_down,         // Charge pump lower
  output logic            synth_clk_en        // Synthesizer clock tick
);

  ckc_speed_t speed_req_r;   // Speed written by software
  ckc_speed_t speed_r;       // Speed in force
  logic       phase_r;       // Oscillator half phase
  logic [2:0] mc_cnt_r;      // Ticks inside the machine cycle
  logic       twi_sel_r;     // two_wire_clk_sel
  logic       wd_sel_r;      // watchdog_clk_sel
  logic       ser_sel_r;     // serial_clk_sel
  logic       t1_sel_r;      // timer1_clk_sel
  logic       t0_sel_r;      // timer0_clk_sel
  logic [1:0] fb_low_r;      // feedback_div_low
  logic       hold_r;        // synth_hold_reset
  logic       en_r;          // synth_enable
  logic [6:0] ref_div_r;     // ref_div_value
  logic [7:0] fb_high_r;     // Feedback divider high bits
  logic [7:0] rdata_r;       // Read data register
  logic       cpu_r;         // CPU tick register
  logic       per_r;         // Peripheral tick register
  logic       mc_r;          // Machine cycle register
  logic       t0_r;          // Timer 0 tick register
  logic       t1_r;          // Timer 1 tick register
  logic       ser_r;         // Serial tick register
  logic       wd_r;          // Watchdog tick register
  logic       twi_r;         // Two-wire tick register
  logic       run_r;         // Synthesizer run register
  logic       hold_out_r;    // Synthesizer hold register
  logic       up_r;          // Raise pulse register
  logic       down_r;        // Lower pulse register
  logic       sclk_r;        // Synthesizer tick register
  logic       per_tick;      // Peripheral tick this cycle
  logic       half_tick;     // Oscillator half tick this cycle
  logic       cpu_tick;      // CPU tick this cycle
  logic       wr_ck;         // Write to clock_control
  logic       wr_pc;         // Write to pll_control
  logic       wr_nd;         // Write to reference divider
  logic       wr_fd;         // Write to feedback divider

  ckc_pfd_if pfd_bus ();     // Link to the detector

  // Picks the oscillator half tick or the peripheral tick for one user
  function automatic logic pick_tick(input logic sel, input logic half,
                                     input logic per, input logic pd);
    pick_tick = (sel ? half : per) & ~pd;
  endfunction

  // Assembles the readable view of a register
  function automatic logic [7:0] read_view(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      CKC_CLOCK_CONTROL_ADDR: begin
        // Reserved bits 5 and 3 return zero
        v[CKC_TWO_WIRE_BIT] = twi_sel_r;
        v[CKC_WATCHDOG_BIT] = wd_sel_r;
        v[CKC_SERIAL_BIT]   = ser_sel_r;
        v[CKC_TIMER1_BIT]   = t1_sel_r;
        v[CKC_TIMER0_BIT]   = t0_sel_r;
        v[CKC_DOUBLE_BIT]   = (speed_req_r == CKC_DOUBLE_SPEED);
      end
      CKC_PLL_CONTROL_ADDR: begin
        // RL17 reserved read zero
        v[CKC_FB_LOW_MSB:CKC_FB_LOW_LSB] = fb_low_r;
        v[CKC_HOLD_BIT]   = hold_r;
        v[CKC_ENABLE_BIT] = en_r;
        v[CKC_LOCK_BIT]   = pfd_bus.locked;
      end
      CKC_REF_DIV_ADDR: begin
        // RL14 top bit zero
        v[CKC_REF_DIV_MSB:0] = ref_div_r;
      end
      CKC_FB_DIV_ADDR: begin
        v = fb_high_r;
      end
      default: begin
        // Unmapped addresses read zero
        v = 8'h00;
      end
    endcase
    read_view = v;
  endfunction

  // Address decode for writes
  assign wr_ck = sfr_wr & (sfr_addr == CKC_CLOCK_CONTROL_ADDR);
  assign wr_pc = sfr_wr & (sfr_addr == CKC_PLL_CONTROL_ADDR);
  assign wr_nd = sfr_wr & (sfr_addr == CKC_REF_DIV_ADDR);
  assign wr_fd = sfr_wr & (sfr_addr == CKC_FB_DIV_ADDR);

  // RL3 tick rate by mode
  assign half_tick = phase_r;
  assign per_tick  = (speed_r == CKC_DOUBLE_SPEED) | phase_r;
  assign cpu_tick  = per_tick & ~idle_mode & ~power_down;

  // Oscillator half phase runs freely
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // Requested speed from software or boot strap
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      // RL4 strap on flash
      if (FLASH_VARIANT && boot_speed_default) begin
        speed_req_r <= CKC_DOUBLE_SPEED;
      end else begin
        // RL2 standard after reset
        speed_req_r <= CKC_STANDARD_SPEED;
      end
    end else if (wr_ck) begin
      speed_req_r <= sfr_wdata[CKC_DOUBLE_BIT] ? CKC_DOUBLE_SPEED
                                               : CKC_STANDARD_SPEED;
    end
  end

  // Speed in force changes only at the end of a half-rate period
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      speed_r <= (FLASH_VARIANT && boot_speed_default) ? CKC_DOUBLE_SPEED
                                                       : CKC_STANDARD_SPEED;
    end else if (phase_r) begin
      // RL21 switch on boundary
      speed_r <= speed_req_r;
    end
  end

  // Peripheral clock selects
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      twi_sel_r <= CKC_CLOCK_CONTROL_RST[CKC_TWO_WIRE_BIT];
      wd_sel_r  <= CKC_CLOCK_CONTROL_RST[CKC_WATCHDOG_BIT];
      ser_sel_r <= CKC_CLOCK_CONTROL_RST[CKC_SERIAL_BIT];
      t1_sel_r  <= CKC_CLOCK_CONTROL_RST[CKC_TIMER1_BIT];
      t0_sel_r  <= CKC_CLOCK_CONTROL_RST[CKC_TIMER0_BIT];
    end else if (wr_ck) begin
      // RL9 reserved bits dropped
      twi_sel_r <= sfr_wdata[CKC_TWO_WIRE_BIT];
      wd_sel_r  <= sfr_wdata[CKC_WATCHDOG_BIT];
      ser_sel_r <= sfr_wdata[CKC_SERIAL_BIT];
      t1_sel_r  <= sfr_wdata[CKC_TIMER1_BIT];
      t0_sel_r  <= sfr_wdata[CKC_TIMER0_BIT];
    end
  end

  // Synthesizer control bits; the lock bit is not stored
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      // RL12 hold set at reset
      fb_low_r <= CKC_PLL_CONTROL_RST[CKC_FB_LOW_MSB:CKC_FB_LOW_LSB];
      hold_r   <= CKC_PLL_CONTROL_RST[CKC_HOLD_BIT];
      en_r     <= CKC_PLL_CONTROL_RST[CKC_ENABLE_BIT];
    end else if (wr_pc) begin
      // RL11 lock write ignored
      fb_low_r <= sfr_wdata[CKC_FB_LOW_MSB:CKC_FB_LOW_LSB];
      hold_r   <= sfr_wdata[CKC_HOLD_BIT];
      en_r     <= sfr_wdata[CKC_ENABLE_BIT];
    end
  end

  // Divider registers
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ref_div_r <= CKC_REF_DIV_RST[CKC_REF_DIV_MSB:0];
      fb_high_r <= CKC_FB_DIV_RST;
    end else begin
      if (wr_nd) begin
        // RL14 seven bit value
        ref_div_r <= sfr_wdata[CKC_REF_DIV_MSB:0];
      end
      if (wr_fd) begin
        fb_high_r <= sfr_wdata;
      end
    end
  end

  // Read data is captured on the read strobe, zero otherwise
  always_ff @(posedge core_clk) begin
    if (!rst_b || !sfr_rd) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= read_view(sfr_addr);
    end
  end

  // Machine cycle counter over CPU ticks
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mc_cnt_r <= 3'd0;
      mc_r     <= 1'b0;
    end else begin
      // RL1 six ticks each
      mc_r <= cpu_tick & (mc_cnt_r == CKC_TICKS_PER_MC - 3'd1);
      if (cpu_tick) begin
        mc_cnt_r <= (mc_cnt_r == CKC_TICKS_PER_MC - 3'd1) ? 3'd0
                                                          : mc_cnt_r + 3'd1;
      end
    end
  end

  // CPU and peripheral clock ticks with power gating
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cpu_r <= 1'b0;
      per_r <= 1'b0;
    end else begin
      // RL19 gated by mode
      cpu_r <= cpu_tick;
      // RL18 shared peripheral tick
      per_r <= per_tick & ~power_down;
    end
  end

  // Per-user clock selection
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      twi_r <= 1'b0;
      wd_r  <= 1'b0;
      ser_r <= 1'b0;
      t1_r  <= 1'b0;
      t0_r  <= 1'b0;
    end else begin
      // RL5 two-wire source
      twi_r <= pick_tick(twi_sel_r, half_tick, per_tick, power_down);
      // RL6 watchdog source
      wd_r  <= pick_tick(wd_sel_r, half_tick, per_tick, power_down);
      // RL7 serial source
      ser_r <= pick_tick(ser_sel_r, half_tick, per_tick, power_down);
      // RL8 timer sources
      t1_r  <= pick_tick(t1_sel_r, half_tick, per_tick, power_down);
      t0_r  <= pick_tick(t0_sel_r, half_tick, per_tick, power_down);
    end
  end

  // Feed the detector
  assign pfd_bus.ref_div_value = ref_div_r;
  // RL13 split feedback divider
  assign pfd_bus.fb_div        = {fb_high_r, fb_low_r};
  assign pfd_bus.hold          = hold_r;
  assign pfd_bus.enable        = en_r & ~power_down;
  assign pfd_bus.vco_tick      = vco_tick;

  // RL15 compare and detect
  ckc_pfd ckc_pfd_i (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pfd_bus  (pfd_bus.pfd)
  );

  // Synthesizer outputs
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      run_r      <= 1'b0;
      hold_out_r <= 1'b1;
      up_r       <= 1'b0;
      down_r     <= 1'b0;
      sclk_r     <= 1'b0;
    end else begin
      // RL10 enable runs loop
      run_r      <= en_r & ~hold_r & ~power_down;
      // RL12 hold to loop
      hold_out_r <= hold_r;
      up_r       <= pfd_bus.up;
      down_r     <= pfd_bus.down;
      // RL20 audio and USB clock
      sclk_r     <= vco_tick & en_r & ~hold_r & ~power_down;
    end
  end

  // Outputs straight from registers
  assign sfr_rdata       = rdata_r;
  assign cpu_clk_en      = cpu_r;
  assign per_clk_en      = per_r;
  assign machine_cycle   = mc_r;
  assign timer0_clk_en   = t0_r;
  assign timer1_clk_en   = t1_r;
  assign serial_clk_en   = ser_r;
  assign watchdog_clk_en = wd_r;
  assign two_wire_clk_en = twi_r;
  assign synth_run       = run_r;
  assign synth_hold      = hold_out_r;
  assign synth_up        = up_r;
  assign synth_down      = down_r;
  assign synth_clk_en    = sclk_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // RL1 cycle spacing check
  mc_spacing_a: assert property (mc_r |=> !mc_r [*5]) // RL1
    else $error("machine cycles closer than six ticks");
  // RL3 standard rate check
  std_rate_a: assert property (per_r && speed_r == CKC_STANDARD_SPEED |=> !per_r) // RL3
    else $error("standard mode peripheral tick not halved");
  // RL3 double rate check
  dbl_rate_a: assert property (speed_r == CKC_DOUBLE_SPEED && !power_down |=> per_r) // RL3
    else $error("double mode peripheral tick missing");
  // RL5 half source check
  twi_half_a: assert property (twi_sel_r && !phase_r |=> !two_wire_clk_en) // RL5
    else $error("two-wire tick off the half phase");
  // RL21 switch point check
  switch_edge_a: assert property (speed_r != $past(speed_r) |-> $past(phase_r)) // RL21
    else $error("speed switched mid period");
  // RL11 lock read check
  lock_read_a: assert property (sfr_rd && sfr_addr == CKC_PLL_CONTROL_ADDR
                                |=> sfr_rdata[0] == $past(pfd_bus.locked)) // RL11
    else $error("lock bit read wrong");
  // RL17 reserved read check
  resv_read_a: assert property (sfr_rd && sfr_addr == CKC_PLL_CONTROL_ADDR
                                |=> sfr_rdata[5:4] == 2'b00 && !sfr_rdata[2]) // RL17
    else $error("reserved control bits read nonzero");
  // RL14 top bit check
  ndiv_top_a: assert property (sfr_rd && sfr_addr == CKC_REF_DIV_ADDR
                               |=> !sfr_rdata[7]) // RL14
    else $error("reference divider top bit nonzero");
  // RL12 hold stops loop
  hold_stop_a: assert property (hold_r |=> !synth_run && !synth_clk_en) // RL12
    else $error("loop runs while held");
  // RL19 power-down gating
  pd_gate_a: assert property (power_down |=> !per_clk_en && !cpu_clk_en) // RL19
    else $error("clock ticks during power down");

endmodule

// ===== testbench/ckc_controller_tb.sv
// Self-checking bench for the clock and synthesizer controller
`timescale 1ns/1ps
module ckc_controller_tb;
  import ckc_pkg::*;
  logic       core_clk, rst_b, sfr_wr, sfr_rd, boot_speed_default; // Stimulus
  logic       idle_mode, power_down, vco_tick, vco_all;            // Stimulus
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_v, wv;            // Register port
  logic       cpu_clk_en, per_clk_en, machine_cycle, timer0_clk_en; // Ticks
  logic       timer1_clk_en, serial_clk_en, watchdog_clk_en;        // Ticks
  logic       two_wire_clk_en, synth_clk_en, synth_up, synth_down;  // Ticks
  logic       synth_run, synth_hold;                                // Synth state
  int         err_total, tests_run, cycles;                         // Bookkeeping
  int         cnt[11];                                              // Tick counts
  int         per_x, m, s, i;                                       // Loop helpers

  ckc_controller ckc_controller_i (.core_clk, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .boot_speed_default, .idle_mode, .power_down, .vco_tick,
    .cpu_clk_en, .per_clk_en, .machine_cycle, .timer0_clk_en, .timer1_clk_en,
    .serial_clk_en, .watchdog_clk_en, .two_wire_clk_en, .synth_run, .synth_hold,
    .synth_up, .synth_down, .synth_clk_en);

  // Clock at 40 MHz
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Random oscillator loop ticks and hang guard
  always @(posedge core_clk) begin
    vco_tick <= vco_all | 1'($urandom % 2);
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end

  // Compare one byte and count it
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Hold reset for ten cycles with the given boot strap
  task automatic do_reset(input logic strap);
    rst_b              <= 1'b0;
    boot_speed_default <= strap;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
  endtask

  // One write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= a;
    sfr_wdata <= d;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  // One read cycle, data taken one cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  // Count every tick output over n settled cycles
  task automatic count(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge core_clk);
      #1;
      cnt[0] += int'(per_clk_en === 1'b1);
      cnt[1] += int'(machine_cycle === 1'b1);
      cnt[2] += int'(cpu_clk_en === 1'b1);
      cnt[3] += int'(timer0_clk_en === 1'b1);
      cnt[4] += int'(timer1_clk_en === 1'b1);
      cnt[5] += int'(serial_clk_en === 1'b1);
      cnt[6] += int'(watchdog_clk_en === 1'b1);
      cnt[7] += int'(two_wire_clk_en === 1'b1);
      cnt[8] += int'(synth_up === 1'b1);
      cnt[9] += int'(synth_down === 1'b1);
      cnt[10] += int'(synth_clk_en === 1'b1);
    end
  endtask

  // Expected peripheral ticks in 48 cycles for a speed mode
  function automatic int per_exp(input int dbl);
    return dbl ? 48 : 24;
  endfunction

  // Print counts and the verdict, then stop
  task automatic results();
    $display("tests_run=%0d err_total=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h24a8));
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, idle_mode, power_down} = '0;
    {rst_b, boot_speed_default, vco_tick, vco_all} = 4'b0100;
    do_reset(1'b1);
    rd(CKC_CLOCK_CONTROL_ADDR, rd_v); chk(rd_v, 8'h01);
    count(48); chk(8'(cnt[0]), 8'd48);
    do_reset(1'b0);
    #1 chk({7'h0, synth_hold}, 8'h01);
    rd(CKC_CLOCK_CONTROL_ADDR, rd_v); chk(rd_v, 8'h00);
    rd(CKC_PLL_CONTROL_ADDR, rd_v); chk(rd_v, 8'h08);
    rd(CKC_REF_DIV_ADDR, rd_v); chk(rd_v, 8'h00);
    rd(CKC_FB_DIV_ADDR, rd_v); chk(rd_v, 8'h00);
    rd(8'h55, rd_v); chk(rd_v, 8'h00);
    // Speed modes against each half-oscillator select
    for (m = 0; m < 2; m++) begin
      for (s = 0; s < 2; s++) begin
        wr(CKC_CLOCK_CONTROL_ADDR, 8'(m) | (s ? 8'hd6 : 8'h00));
        repeat (3) @(posedge core_clk);
        count(48);
        per_x = s ? 24 : per_exp(m);
        chk(8'(cnt[0]), 8'(per_exp(m)));
        chk(8'(cnt[1]), m ? 8'd8 : 8'd4);
        chk(8'(cnt[2]), 8'(per_exp(m)));
        chk(8'(cnt[3]), 8'(per_x));
        chk(8'(cnt[4]), 8'(per_x));
        chk(8'(cnt[5]), 8'(per_x));
        chk(8'(cnt[6]), 8'(per_x));
        chk(8'(cnt[7]), 8'(per_x));
      end
    end
    // Idle stops CPU ticks, power-down stops peripheral, timer 0 and two-wire ticks
    idle_mode <= 1'b1;
    repeat (2) @(posedge core_clk);
    count(48); chk(8'(cnt[2] + cnt[1]), 8'd0); chk(8'(cnt[0]), 8'd48);
    idle_mode  <= 1'b0;
    power_down <= 1'b1;
    repeat (2) @(posedge core_clk);
    count(48); chk(8'(cnt[0] + cnt[3] + cnt[7]), 8'd0);
    power_down <= 1'b0;
    // Synthesizer start and stop
    wr(CKC_PLL_CONTROL_ADDR, 8'h02);
    repeat (3) @(posedge core_clk);
    #1 chk({6'h0, synth_run, synth_hold}, 8'h02);
    wr(CKC_PLL_CONTROL_ADDR, 8'h00);
    repeat (3) @(posedge core_clk);
    #1 chk({7'h0, synth_run}, 8'h00);
    // Random register traffic, reserved bits kept clear
    for (i = 0; i < 8; i++) begin
      wv = 8'($urandom);
      wr(CKC_PLL_CONTROL_ADDR, wv & 8'hca);
      rd(CKC_PLL_CONTROL_ADDR, rd_v); chk(rd_v & 8'hfe, wv & 8'hca);
      wr(CKC_REF_DIV_ADDR, wv);
      rd(CKC_REF_DIV_ADDR, rd_v); chk(rd_v, wv & 8'h7f);
      wr(CKC_FB_DIV_ADDR, ~wv);
      rd(CKC_FB_DIV_ADDR, rd_v); chk(rd_v, ~wv);
      wr(CKC_CLOCK_CONTROL_ADDR, wv & 8'hd7);
      rd(CKC_CLOCK_CONTROL_ADDR, rd_v); chk(rd_v, wv & 8'hd7);
    end
    // Equal dividers on a steady loop tick lock, unequal ones lose it
    vco_all <= 1'b1;
    wr(CKC_PLL_CONTROL_ADDR, 8'h00);
    wr(CKC_REF_DIV_ADDR, 8'h03);
    wr(CKC_FB_DIV_ADDR, 8'h00);
    wr(CKC_PLL_CONTROL_ADDR, 8'hc2);
    repeat (40) @(posedge core_clk);
    count(48); chk(8'(cnt[8] + cnt[9]), 8'd0);
    chk(8'(cnt[10]), 8'd48);
    rd(CKC_PLL_CONTROL_ADDR, rd_v); chk(rd_v, 8'hc3);
    wr(CKC_REF_DIV_ADDR, 8'h0a);
    repeat (40) @(posedge core_clk);
    count(48); chk(8'(cnt[9] > 0), 8'd1);
    rd(CKC_PLL_CONTROL_ADDR, rd_v); chk(rd_v, 8'hc2);
    results();
  end
endmodule
